//--- core/eelc_controller.sv
// Edge event line controller: 32 lines to interrupts, events, wake-up
//
// What this block does
// [RULE1] Thirty-two lines raise interrupt, event or wake-up
// [RULE2] Each line selects rising, falling or both
// [RULE3] Each line masked on its own
// [RULE4] Pending register keeps one bit per line
// [RULE5] Catch pulses shorter than one clock period
// [RULE6] Eighty-seven pins selectable onto sixteen external lines
// [RULE7] Secondary supply comparator drives line thirty-one
// [RULE8] Pending sticks until cleared; interrupt only unmasked
`timescale 1ns/1ns
module eelc_controller (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [eelc_pkg::NUM_GPIO-1:0] i_gpio,
    input wire logic [eelc_pkg::NUM_EXT*eelc_pkg::SEL_W-1:0] i_ext_sel,
    input wire logic [30:16] i_int_src,
    input wire logic i_io2_cmp,
    input wire eelc_pkg::eelc_cfg_t i_cfg,
    input wire logic [31:0] i_pend_clr,
    output eelc_pkg::eelc_out_t o_out
);
    import eelc_pkg::*;

    logic [31:0] src;
    logic [31:0] rise_det;
    logic [31:0] fall_det;
    logic [31:0] hit;
    logic [31:0] pending;
    logic [31:0] next_pending;
    eelc_out_t next_out;

    // Pin chooser for one external line; out-of-range codes give low
    function automatic logic pick_pin(input logic [NUM_GPIO-1:0] pins,
                                      input logic [SEL_W-1:0] sel);
        logic r;
        r = 1'b0;
        if (sel < SEL_W'(NUM_GPIO)) begin
            r = pins[sel];
        end
        return r;
    endfunction : pick_pin

    // [RULE6] External pin selection
    // [RULE7] Supply comparator on line 31
    always_comb begin
        src = '0;
        for (int k = 0; k < NUM_EXT; k++) begin
            src[k] = pick_pin(i_gpio, i_ext_sel[k*SEL_W +: SEL_W]);
        end
        src[30:INT_LO] = i_int_src;
        src[SUPPLY_LINE] = i_io2_cmp;
    end

    // [RULE1] One detector per line
    // [RULE5] Asynchronous capture ahead of sync
    for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
        eelc_edge_capture u_cap (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_line(src[g]),
            .o_rise(rise_det[g]),
            .o_fall(fall_det[g])
        );
    end

    // [RULE2] Edge choice per line
    always_comb begin
        hit = (rise_det & i_cfg.rise_en) | (fall_det & i_cfg.fall_en);
    end

    always_comb begin
        // [RULE4] Pending bits
        // [RULE8] Set beats a clear in the same cycle
        next_pending = (pending & ~i_pend_clr) | hit;
        next_out.pending = next_pending;
        // [RULE3] Independent masks
        // [RULE8] Interrupt only while unmasked
        next_out.irq = next_pending & i_cfg.irq_mask;
        next_out.irq_any = |(next_pending & i_cfg.irq_mask);
        next_out.event_req = hit & i_cfg.evt_mask;
        // Any unmasked trigger may wake the system
        next_out.wakeup = |(hit & (i_cfg.irq_mask | i_cfg.evt_mask));
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending <= LINES_RESET;
            o_out <= '0;
        end else begin
            pending <= next_pending;
            o_out <= next_out;
        end
    end

    a_pend_set: assert property ( // [RULE4]
        @(posedge i_clk) disable iff (!i_rst_n)
        (hit != '0) |=> ((o_out.pending & $past(hit)) == $past(hit)))
    else $error("pending bit missed a triggering edge");

    // A bit may only fall in the cycle after a clear was presented
    a_pend_sticky: assert property ( // [RULE8]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_pend_clr == '0) |=> (($past(pending) & ~pending) == '0))
    else $error("pending bit dropped without a clear");

    a_pend_clear: assert property ( // [RULE8]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_pend_clr != '0) |=>
            ((pending & $past(i_pend_clr & ~hit)) == '0))
    else $error("pending bit survived its clear");

    a_irq_masked: assert property ( // [RULE3]
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 ((o_out.irq & ~$past(i_cfg.irq_mask)) == '0))
    else $error("interrupt raised on a masked line");

    a_irq_follows: assert property ( // [RULE8]
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 (o_out.irq == (pending & $past(i_cfg.irq_mask))))
    else $error("interrupt does not track pending and mask");

    a_evt_cause: assert property ( // [RULE2]
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 (o_out.event_req ==
             ($past((rise_det & i_cfg.rise_en) | (fall_det & i_cfg.fall_en))
              & $past(i_cfg.evt_mask))))
    else $error("event without a selected unmasked edge");

    a_wake_any: assert property ( // [RULE1]
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 (o_out.wakeup ==
             |$past(hit & (i_cfg.irq_mask | i_cfg.evt_mask))))
    else $error("wake-up does not match unmasked triggers");

    a_irq_summary: assert property ( // [RULE1]
        @(posedge i_clk) disable iff (!i_rst_n)
        o_out.irq_any == (o_out.irq != '0))
    else $error("summary interrupt disagrees with line vector");

    // Source routing checks look at the combinational line vector
    a_src_supply: assert property ( // [RULE7]
        @(posedge i_clk) disable iff (!i_rst_n)
        src[SUPPLY_LINE] == i_io2_cmp)
    else $error("line 31 not driven by supply comparator");

    a_src_internal: assert property ( // [RULE1]
        @(posedge i_clk) disable iff (!i_rst_n)
        src[30:INT_LO] == i_int_src)
    else $error("internal sources not routed to their lines");

    a_src_pick: assert property ( // [RULE6]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ext_sel[SEL_W-1:0] < SEL_W'(NUM_GPIO)) |->
            (src[0] == i_gpio[i_ext_sel[SEL_W-1:0]]))
    else $error("external line 0 does not follow its pin");

    a_src_range: assert property ( // [RULE6]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ext_sel[SEL_W-1:0] >= SEL_W'(NUM_GPIO)) |-> !src[0])
    else $error("out-of-range pin code does not read low");

    a_edge_enabled: assert property ( // [RULE2]
        @(posedge i_clk) disable iff (!i_rst_n)
        (hit & ~(i_cfg.rise_en | i_cfg.fall_en)) == '0)
    else $error("trigger on a line with no edge enabled");

    a_evt_masked: assert property ( // [RULE3]
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 ((o_out.event_req & ~$past(i_cfg.evt_mask)) == '0))
    else $error("event raised on a masked line");

    a_pend_out: assert property ( // [RULE4]
        @(posedge i_clk) disable iff (!i_rst_n)
        o_out.pending == pending)
    else $error("pending output differs from pending state");

    // Pending sets even when both masks are off
    a_pend_unmasked: assert property ( // [RULE8]
        @(posedge i_clk) disable iff (!i_rst_n)
        (hit != '0) |=> ((pending & $past(hit)) == $past(hit)))
    else $error("pending state missed a trigger");

    a_wake_quiet: assert property ( // [RULE1]
        @(posedge i_clk) disable iff (!i_rst_n)
        (hit == '0) |=> !o_out.wakeup)
    else $error("wake-up without any trigger");

    a_evt_quiet: assert property ( // [RULE2]
        @(posedge i_clk) disable iff (!i_rst_n)
        (hit == '0) |=> (o_out.event_req == '0))
    else $error("event without any trigger");
endmodule : eelc_controller

//--- core/eelc_edge_capture.sv
// Asynchronous edge catcher with toggle crossing for one line
`timescale 1ns/1ns
module eelc_edge_capture (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_line,
    output logic o_rise,
    output logic o_fall
);
    import eelc_pkg::*;

    logic rise_tgl;
    logic fall_tgl;
    logic [SYNC_STAGES:0] rise_sync;
    logic [SYNC_STAGES:0] fall_sync;
    logic next_rise;
    logic next_fall;

    // Toggles are clocked by the line itself, so a pulse far shorter
    // than one i_clk period still flips them and is not lost
    always_ff @(posedge i_line or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rise_tgl <= CAPTURE_RESET;
        end else begin
            rise_tgl <= ~rise_tgl;
        end
    end

    always_ff @(negedge i_line or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fall_tgl <= CAPTURE_RESET;
        end else begin
            fall_tgl <= ~fall_tgl;
        end
    end

    // Stage 0 is read only by stage 1; edges come from the later stages
    always_comb begin
        next_rise = rise_sync[SYNC_STAGES] ^ rise_sync[SYNC_STAGES-1];
        next_fall = fall_sync[SYNC_STAGES] ^ fall_sync[SYNC_STAGES-1];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rise_sync <= '0;
            fall_sync <= '0;
            o_rise <= 1'b0;
            o_fall <= 1'b0;
        end else begin
            rise_sync <= {rise_sync[SYNC_STAGES-1:0], rise_tgl};
            fall_sync <= {fall_sync[SYNC_STAGES-1:0], fall_tgl};
            o_rise <= next_rise;
            o_fall <= next_fall;
        end
    end
endmodule : eelc_edge_capture

//--- core/eelc_pkg.sv
// Shared types and constants for the edge event line controller
package eelc_pkg;
    localparam int unsigned NUM_LINES = 32;
    localparam int unsigned NUM_EXT = 16;
    localparam int unsigned NUM_GPIO = 87;
    localparam int unsigned SEL_W = 7;
    localparam int unsigned SUPPLY_LINE = 31;
    localparam int unsigned INT_LO = 16;
    localparam int unsigned SYNC_STAGES = 2;
    localparam logic [31:0] LINES_RESET = 32'h0000_0000;
    localparam logic CAPTURE_RESET = 1'b0;

    // Per-line configuration carried as one group
    typedef struct packed {
        logic [31:0] rise_en;
        logic [31:0] fall_en;
        logic [31:0] irq_mask;
        logic [31:0] evt_mask;
    } eelc_cfg_t;

    // Outputs toward the interrupt controller and power control
    typedef struct packed {
        logic [31:0] pending;
        logic [31:0] irq;
        logic [31:0] event_req;
        logic irq_any;
        logic wakeup;
    } eelc_out_t;
endpackage : eelc_pkg

//--- tb/eelc_controller_tb.sv
// Self-checking bench for the edge event line controller
`timescale 1ns/1ns
module eelc_controller_tb;
    import eelc_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [86:0] gpio = '0;
    logic [111:0] ext_sel = '0;
    logic [30:16] int_src = '0;
    logic io2 = 1'b0;
    eelc_cfg_t cfg = '0;
    logic [31:0] tb_clr = '0;
    logic [31:0] mdl_clr;
    logic [3:0] lat = 4'hf;
    eelc_out_t out;
    logic [32:0] evq[$];
    logic [31:0] pend = '0;
    logic [31:0] rnd = 32'h93355fdc;
    int bad_count = 0;
    int checks_done = 0;
    int pin[16];
    always #5 i_clk = ~i_clk;
    eelc_controller uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_gpio(gpio),
        .i_ext_sel(ext_sel), .i_int_src(int_src), .i_io2_cmp(io2),
        .i_cfg(cfg), .i_pend_clr(tb_clr | mdl_clr), .o_out(out));
    eelc_irq_model irq_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_irq(out.irq), .i_lat(lat), .o_clr(mdl_clr));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic fail(input string msg);
        bad_count++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail
    task automatic cmp_evt(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp) fail("event or wakeup mismatch");
    endtask : cmp_evt
    task automatic cmp_pend(input logic [31:0] exp);
        checks_done++;
        if (out.pending !== exp || out.irq !== (exp & cfg.irq_mask)
            || out.irq_any !== |(exp & cfg.irq_mask)) fail("pending mismatch");
    endtask : cmp_pend
    task automatic tally_and_finish();
        if (evq.size() != 0) fail("missing event");
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic drive(input int k, input logic v);
        if (k < 16) gpio[pin[k]] <= v;
        else if (k < 31) int_src[k] <= v;
        else io2 <= v;
    endtask : drive
    task automatic step(input int k, input logic v, input logic hit);
        logic ev;
        logic wk;
        ev = hit & cfg.evt_mask[k];
        wk = hit & (cfg.evt_mask[k] | cfg.irq_mask[k]);
        if (wk) evq.push_back({wk, 32'(ev) << k});
        @(posedge i_clk) drive(k, v);
        if (hit) pend[k] = 1'b1;
        repeat (8) @(posedge i_clk);
        cmp_pend(pend);
        repeat (25) @(posedge i_clk);
        pend = pend & ~cfg.irq_mask;
        cmp_pend(pend);
        tb_clr <= '1;
        @(posedge i_clk) tb_clr <= '0;
        pend = '0;
    endtask : step
    always @(posedge i_clk) begin
        if (i_rst_n && (out.wakeup === 1'b1 || out.event_req !== '0)) begin
            if (evq.size() == 0) fail("unexpected event");
            else cmp_evt({out.wakeup, out.event_req}, evq.pop_front());
        end
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rnd = xs(rnd);
        // One random base keeps the sixteen pins distinct
        for (int k = 0; k < 16; k++) begin
            pin[k] = (k * 5 + rnd % 87) % 87;
            ext_sel[k*7 +: 7] <= 7'(pin[k]);
        end
        for (int k = 0; k < 32; k++) begin
            // Random masks on all lines also exercise line independence
            for (int j = 0; j < 4; j++) begin
                rnd = xs(rnd);
                cfg[j*32 +: 32] <= rnd;
            end
            lat <= 4'ha + 4'(rnd[7:4] % 6);
            @(posedge i_clk);
            step(k, 1'b1, cfg.rise_en[k]);
            step(k, 1'b0, cfg.fall_en[k]);
        end
        cfg <= {32'hffffffff, 32'h0, 32'hffffffff, 32'hffffffff};
        @(posedge i_clk);
        evq.push_back({1'b1, 32'h1});
        // Pulse far shorter than one clock period, placed mid-cycle
        #2 gpio[pin[0]] = 1'b1;
        #3 gpio[pin[0]] = 1'b0;
        repeat (8) @(posedge i_clk);
        cmp_pend(32'h1);
        repeat (30) @(posedge i_clk);
        tally_and_finish();
    end
    initial begin
        #300000;
        fail("watchdog expired");
        tally_and_finish();
    end
endmodule : eelc_controller_tb

//--- tb/eelc_irq_model.sv
// Interrupt controller stand-in: clears serviced lines after a delay
`timescale 1ns/1ns
module eelc_irq_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [31:0] i_irq,
    input wire logic [3:0] i_lat,
    output logic [31:0] o_clr
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [31:0] next_clr;
    always_comb begin
        next_cnt = cnt + 4'h1;
        next_clr = '0;
        if (i_irq == '0) begin
            next_cnt = '0;
        end else if (cnt == i_lat) begin
            next_clr = i_irq;
            next_cnt = '0;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= '0;
            o_clr <= '0;
        end else begin
            cnt <= next_cnt;
            o_clr <= next_clr;
        end
    end
endmodule : eelc_irq_model
